// [common/ccrb_regs.vh]
// Purpose: constants for the charger control register bank
// Assumes: 8-bit registers reached over a two-wire serial target port
// Notes: offsets, reset values, field positions and timing figures
`ifndef CCRB_REGS_VH
`define CCRB_REGS_VH

// Serial target address (7 bits, value arbitrary) and byte width
`define CCRB_TARGET_ADDR 7'h2a
`define CCRB_BYTE_BITS 4'h8

// Register offsets
`define CCRB_OFS_MASK_B 8'h09
`define CCRB_OFS_MASK_C 8'h0a
`define CCRB_OFS_BATTHR 8'h0c
`define CCRB_OFS_OUTREG 8'h0d
`define CCRB_OFS_POLICY 8'h0e
`define CCRB_OFS_THERM 8'h0f
`define CCRB_OFS_FLOAT 8'h11
`define CCRB_OFS_FASTI 8'h12
`define CCRB_OFS_TERMI 8'h13

// Reset values
`define CCRB_RST_MASK_B 8'h00
`define CCRB_RST_MASK_C 8'h00
`define CCRB_RST_BATTHR 8'h3f
`define CCRB_RST_OUTREG 8'h57
`define CCRB_RST_POLICY 8'h1c
`define CCRB_RST_THERM 8'h40
`define CCRB_RST_FLOAT 8'h69
`define CCRB_RST_FASTI 8'h10
`define CCRB_RST_TERMI 8'h98

// Writable and fixed bit patterns
`define CCRB_MASK_B_WR 8'hfd
`define CCRB_BATTHR_WR 8'h3f
`define CCRB_OUTREG_WR 8'hfb
`define CCRB_OUTREG_FIX 8'h04
`define CCRB_POLICY_RD 8'h3e
`define CCRB_THERM_RD 8'h67
`define CCRB_FASTI_WR 8'h3f
`define CCRB_FASTI_MAX 6'h3c

// Field positions
`define CCRB_GOOD_THR 5:3
`define CCRB_MIN_THR 2:0
`define CCRB_GPO_TWO 7
`define CCRB_GPO_ONE 6
`define CCRB_REG_OFF 5
`define CCRB_REG_SEL 4:3
`define CCRB_SYS_SEL 1:0
`define CCRB_IGN_TMR 7
`define CCRB_RCHG_DIS 5
`define CCRB_NOBAT_OPT 4
`define CCRB_CUTOFF_ON 3
`define CCRB_TOPOFF 2
`define CCRB_HIZ 1
`define CCRB_SOFT_RST 7
`define CCRB_TREG 6:5
`define CCRB_AUTO_SHIP 2
`define CCRB_BSW_OFF 1
`define CCRB_CHG_DIS 0
`define CCRB_MASK_TMR 0
`define CCRB_FASTI_FLD 5:0
`define CCRB_TERM_FLD 7:4
`define CCRB_PRE_FLD 3:0

// Battery absence retest period
`define CCRB_NOBAT_PERIOD_S 2
`define CCRB_CLK_HZ 250000000

`endif

// [core/ccrb_top.v]
// Purpose: charger control register bank behind a two-wire serial target
// Assumes: all inputs synchronous to clk; sda is open drain
// Notes: single clock; ce low freezes every flip-flop
//
// Functional notes
// - A set mask bit keeps its flag from pulling the interrupt request low.
// - Timer flag mask only works with ignore-timer set; expiry otherwise clears it.
// - Good-battery threshold 3.0 to 3.7 V at bits 5:3, default 111.
// - Minimum battery threshold 2.7 to 3.4 V at bits 2:0, default 111.
// - Two general outputs driven high by their bits; defaults zero and one.
// - Regulator disable bit and two-bit voltage select, default code 10.
// - With ignore-timer set, expiry keeps charging but still raises status and flag.
// - With ignore-timer clear, expiry resets registers and sends charger idle.
// - Auto recharge disable bit blocks recharge restart.
// - No-battery option retests absence every 2 s; battery switch opens.
// - Current cutoff bit enables termination on low current.
// - Top-off bit enables top-off charging after normal cycle.
// - High impedance request, ignored under boost, cleared and locked on low battery.
// - Writing one to soft reset bit restores defaults; it reads zero.
// - Thermal regulation threshold select at bits 6:5, default 10.
// - Auto ship mode sets battery switch off on source drop; clears on connect.
// - Battery switch off opens the switch; clears on source events as described.
// - Float voltage code 3.3 to 4.72 V in 10 mV steps, default 69h.
// - Fast charge current code 0.2 to 3.2 A; codes above 3Ch act as 3Ch.
// - Termination current code at bits 7:4, default 1001.
// - Pre-charge current code at bits 3:0, default 1000.
`timescale 1ns/100ps
`default_nettype none
`include "ccrb_regs.vh"

module ccrb_top #(
  parameter [31:0] NOBAT_PERIOD_CYCLES = `CCRB_NOBAT_PERIOD_S * `CCRB_CLK_HZ
) (
  // Clock, reset, enable
  input wire clk,
  input wire nrst,
  input wire ce,
  // Serial target pins
  input wire scl,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  // Charger events and levels
  input wire [7:0] flags_group_b,
  input wire [7:0] flags_group_c,
  input wire timer_expired,
  input wire source_connected,
  input wire source_removed,
  input wire battery_below_min,
  input wire boost_on,
  input wire battery_absent,
  input wire recharge_due,
  input wire current_below_term,
  // Interrupt request from these flag groups
  output reg irq_group_bc_n,
  // Configuration outputs
  output reg [7:0] irq_mask_group_b,
  output reg [7:0] irq_mask_group_c,
  output reg [7:0] battery_threshold_config,
  output reg [7:0] output_regulator_config,
  output reg [7:0] charge_policy_config,
  output reg [7:0] thermal_ship_config,
  output reg [7:0] float_voltage,
  output reg [7:0] fast_charge_current,
  output reg [7:0] termination_precharge_current,
  output reg [5:0] fast_charge_current_code,
  output reg high_impedance_active,
  output reg battery_switch_open,
  // Charger action pulses
  output reg safety_timer_expired_status,
  output reg charger_idle_request,
  output reg absence_test_pulse,
  output reg recharge_start,
  output reg charge_terminate
);

  // Serial engine states
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_ADDR = 3'h1;
  localparam [2:0] S_PTR = 3'h2;
  localparam [2:0] S_WR = 3'h3;
  localparam [2:0] S_RD = 3'h4;

  // Serial engine registers
  reg [2:0] state;
  reg scl_q;
  reg sda_q;
  reg [3:0] bit_cnt;
  reg ack_phase;
  reg [7:0] shreg;
  reg [7:0] rd_sh;
  reg [7:0] ptr;
  // One-cycle write strobe with the offset and byte it carries
  reg wr_stb;
  reg [7:0] wr_addr;
  reg [7:0] wr_data;
  // Read mux output and retest counter
  reg [7:0] rdata;
  reg [31:0] nobat_cnt;

  // Edge and condition detect on sampled lines; sample flops reset
  // to the idle-high level so no false start follows reset
  wire scl_rise = scl & ~scl_q;
  wire scl_fall = ~scl & scl_q;
  wire start_seen = scl & scl_q & sda_q & ~sda_in;
  wire stop_seen = scl & scl_q & ~sda_q & sda_in;
  // Bank-wide default sources: expiry without ignore-timer,
  // or a one written to the soft reset bit
  wire ign_tmr = charge_policy_config[`CCRB_IGN_TMR];
  wire expiry_reset = timer_expired & ~ign_tmr;
  wire soft_reset = wr_stb & (wr_addr == `CCRB_OFS_THERM) & wr_data[`CCRB_SOFT_RST];
  wire defaults = expiry_reset | soft_reset;

  // Read mux; reserved bits return their fixed values
  always @* begin
    // Follows the live pointer; the engine loads it per byte
    if (ptr == `CCRB_OFS_MASK_B) begin
      rdata = irq_mask_group_b & `CCRB_MASK_B_WR;
    end else if (ptr == `CCRB_OFS_MASK_C) begin
      rdata = irq_mask_group_c;
    end else if (ptr == `CCRB_OFS_BATTHR) begin
      rdata = battery_threshold_config;
    end else if (ptr == `CCRB_OFS_OUTREG) begin
      rdata = output_regulator_config | `CCRB_OUTREG_FIX;
    end else if (ptr == `CCRB_OFS_POLICY) begin
      rdata = charge_policy_config & `CCRB_POLICY_RD;
    end else if (ptr == `CCRB_OFS_THERM) begin
      rdata = thermal_ship_config & `CCRB_THERM_RD;
    end else if (ptr == `CCRB_OFS_FLOAT) begin
      rdata = float_voltage;
    end else if (ptr == `CCRB_OFS_FASTI) begin
      rdata = fast_charge_current;
    end else if (ptr == `CCRB_OFS_TERMI) begin
      rdata = termination_precharge_current;
    end else begin
      rdata = 8'h00;
    end
  end

  // Serial target engine; sda changes only while scl is low
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= S_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bit_cnt <= 4'h0;
      ack_phase <= 1'b0;
      shreg <= 8'h00;
      rd_sh <= 8'h00;
      ptr <= 8'h00;
      wr_stb <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else if (ce) begin
      scl_q <= scl;
      sda_q <= sda_in;
      wr_stb <= 1'b0;
      sda_out <= 1'b0; // Open drain: only ever pulls low
      // Start and stop win over bit traffic; a repeated start
      // restarts address matching and leaves the pointer alone
      if (start_seen) begin
        state <= S_ADDR;
        bit_cnt <= 4'h0;
        ack_phase <= 1'b0;
        sda_oe <= 1'b0;
      end else if (stop_seen) begin
        state <= S_IDLE;
        ack_phase <= 1'b0;
        sda_oe <= 1'b0;
      end else if (scl_rise && state != S_IDLE) begin
        if (ack_phase) begin
          // Controller not-acknowledge ends a read burst
          if (state == S_RD && sda_in) begin
            state <= S_IDLE;
          end
        end else if (bit_cnt < `CCRB_BYTE_BITS) begin
          shreg <= {shreg[6:0], sda_in};
          bit_cnt <= bit_cnt + 4'h1;
        end
      end else if (scl_fall && state != S_IDLE) begin
        if (ack_phase) begin
          // Ack slot over: load the next read byte or free the line
          ack_phase <= 1'b0;
          bit_cnt <= 4'h0;
          if (state == S_RD) begin
            rd_sh <= rdata;
            sda_oe <= ~rdata[7];
          end else begin
            sda_oe <= 1'b0;
          end
        end else if (bit_cnt == `CCRB_BYTE_BITS) begin
          ack_phase <= 1'b1;
          case (state)
            S_ADDR: begin
              if (shreg[7:1] == `CCRB_TARGET_ADDR) begin
                sda_oe <= 1'b1;
                state <= shreg[0] ? S_RD : S_PTR;
              end else begin
                state <= S_IDLE;
                ack_phase <= 1'b0;
              end
            end
            S_PTR: begin
              ptr <= shreg;
              sda_oe <= 1'b1;
              state <= S_WR;
            end
            S_WR: begin
              // One strobe per data byte; the pointer steps for bursts
              wr_stb <= 1'b1;
              wr_addr <= ptr;
              wr_data <= shreg;
              ptr <= ptr + 8'h01;
              sda_oe <= 1'b1;
            end
            default: begin
              // Read byte done: release for controller acknowledge
              sda_oe <= 1'b0;
              ptr <= ptr + 8'h01;
            end
          endcase
        end else if (state == S_RD) begin
          // Mid-byte fall: next read bit goes out while scl is low
          rd_sh <= {rd_sh[6:0], 1'b0};
          sda_oe <= ~rd_sh[6];
        end
      end
    end
  end

  // Register file; hardware events are applied after the bus write so they win
  // Limitation: a soft reset also drops the rest of that byte
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_mask_group_b <= `CCRB_RST_MASK_B;
      irq_mask_group_c <= `CCRB_RST_MASK_C;
      battery_threshold_config <= `CCRB_RST_BATTHR;
      output_regulator_config <= `CCRB_RST_OUTREG;
      charge_policy_config <= `CCRB_RST_POLICY;
      thermal_ship_config <= `CCRB_RST_THERM;
      float_voltage <= `CCRB_RST_FLOAT;
      fast_charge_current <= `CCRB_RST_FASTI;
      termination_precharge_current <= `CCRB_RST_TERMI;
    end else if (ce) begin
      // Defaults beat the bus and every event in the same cycle
      if (defaults) begin
        // Whole bank back to defaults
        irq_mask_group_b <= `CCRB_RST_MASK_B;
        irq_mask_group_c <= `CCRB_RST_MASK_C;
        battery_threshold_config <= `CCRB_RST_BATTHR;
        output_regulator_config <= `CCRB_RST_OUTREG;
        charge_policy_config <= `CCRB_RST_POLICY;
        thermal_ship_config <= `CCRB_RST_THERM;
        float_voltage <= `CCRB_RST_FLOAT;
        fast_charge_current <= `CCRB_RST_FASTI;
        termination_precharge_current <= `CCRB_RST_TERMI;
      end else begin
        if (wr_stb) begin
          // Address decode; reserved bits keep fixed values
          if (wr_addr == `CCRB_OFS_MASK_B) begin
            irq_mask_group_b <= wr_data & `CCRB_MASK_B_WR;
          end else if (wr_addr == `CCRB_OFS_MASK_C) begin
            irq_mask_group_c <= wr_data;
          end else if (wr_addr == `CCRB_OFS_BATTHR) begin
            battery_threshold_config <= wr_data & `CCRB_BATTHR_WR;
          end else if (wr_addr == `CCRB_OFS_OUTREG) begin
            output_regulator_config <= (wr_data & `CCRB_OUTREG_WR) | `CCRB_OUTREG_FIX;
          end else if (wr_addr == `CCRB_OFS_POLICY) begin
            // Bit by bit, so reserved bit 6 keeps its fixed zero
            charge_policy_config[`CCRB_IGN_TMR] <= wr_data[`CCRB_IGN_TMR];
            charge_policy_config[`CCRB_RCHG_DIS] <= wr_data[`CCRB_RCHG_DIS];
            charge_policy_config[`CCRB_NOBAT_OPT] <= wr_data[`CCRB_NOBAT_OPT];
            charge_policy_config[`CCRB_CUTOFF_ON] <= wr_data[`CCRB_CUTOFF_ON];
            charge_policy_config[`CCRB_TOPOFF] <= wr_data[`CCRB_TOPOFF];
            charge_policy_config[`CCRB_CHG_DIS] <= wr_data[`CCRB_CHG_DIS];
            if (!battery_below_min) begin
              charge_policy_config[`CCRB_HIZ] <= wr_data[`CCRB_HIZ];
            end
          end else if (wr_addr == `CCRB_OFS_THERM) begin
            thermal_ship_config <= wr_data & `CCRB_THERM_RD;
          end else if (wr_addr == `CCRB_OFS_FLOAT) begin
            float_voltage <= wr_data;
          end else if (wr_addr == `CCRB_OFS_FASTI) begin
            fast_charge_current <= wr_data & `CCRB_FASTI_WR;
          end else if (wr_addr == `CCRB_OFS_TERMI) begin
            termination_precharge_current <= wr_data;
          end
        end
        // Timer mask cleared on expiry unless ignore-timer is set
        if (timer_expired && !ign_tmr) begin
          irq_mask_group_c[`CCRB_MASK_TMR] <= 1'b0;
        end
        // Low battery clears the high impedance request
        if (battery_below_min) begin
          charge_policy_config[`CCRB_HIZ] <= 1'b0;
        end
        // Ship mode and battery switch source events
        // Connect outranks removal when both come in one cycle
        if (source_connected) begin
          thermal_ship_config[`CCRB_AUTO_SHIP] <= 1'b0;
          thermal_ship_config[`CCRB_BSW_OFF] <= 1'b0;
        end else if (source_removed) begin
          thermal_ship_config[`CCRB_BSW_OFF] <= thermal_ship_config[`CCRB_AUTO_SHIP];
        end
      end
    end
  end

  // Derived outputs and event pulses, all registered
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_group_bc_n <= 1'b1;
      fast_charge_current_code <= 6'h00;
      high_impedance_active <= 1'b0;
      battery_switch_open <= 1'b0;
      safety_timer_expired_status <= 1'b0;
      charger_idle_request <= 1'b0;
      recharge_start <= 1'b0;
      charge_terminate <= 1'b0;
    end else if (ce) begin
      // Timer flag mask counts only while ignore-timer is set
      irq_group_bc_n <= ~(|(flags_group_b & ~(irq_mask_group_b & `CCRB_MASK_B_WR)) |
        |(flags_group_c[7:1] & ~irq_mask_group_c[7:1]) |
        (flags_group_c[0] & ~(irq_mask_group_c[`CCRB_MASK_TMR] & ign_tmr)));
      // Codes above the top step act as the top step
      if (fast_charge_current[`CCRB_FASTI_FLD] > `CCRB_FASTI_MAX) begin
        fast_charge_current_code <= `CCRB_FASTI_MAX;
      end else begin
        fast_charge_current_code <= fast_charge_current[`CCRB_FASTI_FLD];
      end
      // Boost hides the request without clearing it, so the
      // high impedance state comes back once boost ends
      high_impedance_active <= charge_policy_config[`CCRB_HIZ] & ~boost_on;
      // Switch opens for ship mode or while a battery is missing with the no-battery option set
      battery_switch_open <= thermal_ship_config[`CCRB_BSW_OFF] |
        (battery_absent & charge_policy_config[`CCRB_NOBAT_OPT]);
      // Status follows every expiry, whatever the ignore bit says
      safety_timer_expired_status <= timer_expired;
      charger_idle_request <= expiry_reset;
      // Restart needs cutoff on and recharge not disabled
      recharge_start <= recharge_due & charge_policy_config[`CCRB_CUTOFF_ON] &
        ~charge_policy_config[`CCRB_RCHG_DIS];
      // With cutoff off the charger keeps going below threshold
      charge_terminate <= current_below_term & charge_policy_config[`CCRB_CUTOFF_ON];
    end
  end

  // Absence retest ticker; free counter idles when no retest is needed
  // Limitation: 32 bits cover the 2 s period up to about 8 times this clock;
  // a much faster clock would need a wider counter
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      nobat_cnt <= 32'h00000000;
      absence_test_pulse <= 1'b0;
    end else if (ce) begin
      absence_test_pulse <= 1'b0;
      if (battery_absent && charge_policy_config[`CCRB_NOBAT_OPT]) begin
        // Period end: one pulse, then count again from zero
        if (nobat_cnt >= NOBAT_PERIOD_CYCLES - 32'h00000001) begin
          nobat_cnt <= 32'h00000000;
          absence_test_pulse <= 1'b1;
        end else begin
          nobat_cnt <= nobat_cnt + 32'h00000001;
        end
      end else begin
        nobat_cnt <= 32'h00000000;
      end
    end
  end

endmodule // ccrb_top
`default_nettype wire

// [bench/ccrb_host_model.sv]
// Purpose: serial bus controller model for the charger register bank
// Assumes: the bench resolves sda as sda_m unless the device drives it
// Notes: each data-bit scl phase is 4 clk, start holds scl high 8; sda moves at least 2 clk away from scl edges
`timescale 1ns/100ps
`default_nettype none
`include "ccrb_regs.vh"
module ccrb_host_model (
  // Clock
  input wire logic clk,
  // Bus lines
  output logic scl,
  output logic sda_m,
  input wire logic sda
);
  // Bus idles released
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task w(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Start and repeated start share one shape
  task start;
    sda_m <= 1'b1;
    w(2);
    scl <= 1'b1;
    w(4);
    sda_m <= 1'b0;
    w(4);
    scl <= 1'b0;
    w(2);
  endtask
  task stop;
    sda_m <= 1'b0;
    w(2);
    scl <= 1'b1;
    w(4);
    sda_m <= 1'b1;
    w(4);
  endtask
  // Nine bits MSB first; a one releases the line
  task bits(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      sda_m <= d[i];
      w(2);
      scl <= 1'b1;
      w(4);
      q[i] = sda;
      scl <= 1'b0;
      w(2);
    end
  endtask
  // Write; ok only if every byte was acknowledged
  task wr(input logic [6:0] a, input logic [7:0] ofs, input logic [7:0] v, output logic ok);
    logic [8:0] q;
    start;
    bits({a, 2'b01}, q);
    ok = ~q[0];
    bits({ofs, 1'b1}, q);
    ok = ok & ~q[0];
    bits({v, 1'b1}, q);
    ok = ok & ~q[0];
    stop;
  endtask
  // Read ends with a controller nack
  task rd(input logic [7:0] ofs, output logic [7:0] v);
    logic [8:0] q;
    start;
    bits({`CCRB_TARGET_ADDR, 2'b01}, q);
    bits({ofs, 1'b1}, q);
    start;
    bits({`CCRB_TARGET_ADDR, 2'b11}, q);
    bits(9'h1ff, q);
    v = q[8:1];
    stop;
  endtask
endmodule // ccrb_host_model
`default_nettype wire

// [bench/ccrb_top_assertions.sv]
// Purpose: port-level checks of the charger register bank
// Assumes: single clock, nrst async active low
// Notes: irq and mask checks skip cycles with ce low
`timescale 1ns/100ps
`default_nettype none
module ccrb_top_assertions (
  // Clock and controls
  input wire clk,
  input wire nrst,
  input wire ce,
  // Events
  input wire [7:0] flags_group_b,
  input wire timer_expired,
  input wire source_connected,
  input wire source_removed,
  input wire boost_on,
  input wire battery_absent,
  input wire recharge_due,
  input wire current_below_term,
  // Outputs
  input wire irq_group_bc_n,
  input wire [7:0] irq_mask_group_b,
  input wire [7:0] irq_mask_group_c,
  input wire [7:0] charge_policy_config,
  input wire [7:0] thermal_ship_config,
  input wire [7:0] fast_charge_current,
  input wire [5:0] fast_charge_current_code,
  input wire high_impedance_active,
  input wire battery_switch_open,
  input wire safety_timer_expired_status,
  input wire charger_idle_request,
  input wire recharge_start,
  input wire charge_terminate,
  input wire absence_test_pulse
);
  // Helpers keep $past on plain signals
  wire [5:0] fast_field = fast_charge_current[5:0];
  wire rchg_cause = recharge_due & charge_policy_config[3] & ~charge_policy_config[5];
  wire term_cause = current_below_term & charge_policy_config[3];
  wire [5:0] fast_clamped = fast_field > 6'h3c ? 6'h3c : fast_field;
  wire dft_seen = fast_charge_current == 8'h10 && !irq_mask_group_c[0];
  wire ship_drop = source_removed & ~source_connected & thermal_ship_config[2];
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  a_flag_pulls_low: assert property (ce && |(flags_group_b & ~irq_mask_group_b) |=> !irq_group_bc_n)
    else $error("unmasked flag left irq high");
  a_expiry_status: assert property (ce && timer_expired |=> safety_timer_expired_status)
    else $error("no expiry status pulse");
  a_idle_defaults: assert property (charger_idle_request |-> $past(timer_expired) && dft_seen)
    else $error("idle without defaults");
  a_fast_clamp: assert property (ce |=> fast_charge_current_code == $past(fast_clamped))
    else $error("fast code not clamped");
  a_recharge_gate: assert property (ce |=> recharge_start == $past(rchg_cause))
    else $error("recharge start wrong");
  a_cutoff_gate: assert property (ce |=> charge_terminate == $past(term_cause))
    else $error("terminate wrong");
  a_hz_under_boost: assert property (ce && boost_on |=> !high_impedance_active)
    else $error("hz active under boost");
  a_nobat_switch: assert property (ce && battery_absent && charge_policy_config[4] |=> battery_switch_open)
    else $error("switch closed without battery");
  a_nobat_gap: assert property (absence_test_pulse |=> !absence_test_pulse [*8])
    else $error("absence pulses too close");
  a_ship_on_drop: assert property (ce && ship_drop |=> thermal_ship_config[1])
    else $error("ship mode did not open switch");
  a_connect_clears: assert property (ce && source_connected |=> thermal_ship_config[2:1] == 2'b00)
    else $error("connect left ship bits");
endmodule // ccrb_top_assertions
bind ccrb_top ccrb_top_assertions ccrb_top_assertions_i (.*);
`default_nettype wire

// [bench/tb_top.sv]
// Purpose: self-checking bench for the charger register bank
// Assumes: sda follows sda_m unless the device drives; device only pulls low
// Notes: short absence period keeps the run brief
`timescale 1ns/100ps
`default_nettype none
`include "ccrb_regs.vh"
module tb_top;
  localparam int PER = 20;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] fb = 8'h00, fc = 8'h00, d, v, got;
  logic tmr = 1'b0, scon = 1'b0, srem = 1'b0, blow = 1'b0, boost = 1'b0;
  logic absent = 1'b0, rdue = 1'b0, cbt = 1'b0, ok;
  wire scl, sda_m, sda_out, sda_oe, irq_n, hz, bsw, stat, idle, abs_p;
  wire sda = sda_oe ? sda_out : sda_m;
  wire [7:0] mb, mc, r0c, r0d, r0e, r0f, r11, r12, r13;
  wire [5:0] fcode;
  int errors = 0, checks_done = 0, seed = 3525, n;
  logic [7:0] ofs [9] = '{8'h09, 8'h0a, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h11, 8'h12, 8'h13};
  logic [7:0] dft [9] = '{8'h00, 8'h00, 8'h3f, 8'h57, 8'h1c, 8'h40, 8'h69, 8'h10, 8'h98};
  logic [7:0] fv [3] = '{8'h3b, 8'h3c, 8'h3f};
  always #2 clk = ~clk;
  ccrb_top #(.NOBAT_PERIOD_CYCLES(PER)) ccrb_top_i (.clk(clk), .nrst(nrst), .ce(1'b1), .scl(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .flags_group_b(fb), .flags_group_c(fc),
    .timer_expired(tmr), .source_connected(scon), .source_removed(srem), .battery_below_min(blow),
    .boost_on(boost), .battery_absent(absent), .recharge_due(rdue), .current_below_term(cbt),
    .irq_group_bc_n(irq_n), .irq_mask_group_b(mb), .irq_mask_group_c(mc), .battery_threshold_config(r0c),
    .output_regulator_config(r0d), .charge_policy_config(r0e), .thermal_ship_config(r0f),
    .float_voltage(r11), .fast_charge_current(r12), .termination_precharge_current(r13),
    .fast_charge_current_code(fcode), .high_impedance_active(hz), .battery_switch_open(bsw),
    .safety_timer_expired_status(stat), .charger_idle_request(idle), .absence_test_pulse(abs_p),
    .recharge_start(), .charge_terminate());
  ccrb_host_model ccrb_host_model_i (.clk(clk), .scl(scl), .sda_m(sda_m), .sda(sda));
  // Read-back view: reserved bits fixed, write-only bits read zero
  function automatic logic [7:0] exp_rd(input logic [7:0] a, input logic [7:0] x);
    case (a)
      8'h09: exp_rd = x & 8'hfd;
      8'h0a, 8'h11, 8'h13: exp_rd = x;
      8'h0c, 8'h12: exp_rd = x & 8'h3f;
      8'h0d: exp_rd = (x & 8'hfb) | 8'h04;
      8'h0e: exp_rd = x & 8'h3e;
      8'h0f: exp_rd = x & 8'h67;
      default: exp_rd = 8'h00;
    endcase
  endfunction
  // Port view of the register at table index i
  function automatic logic [7:0] port_of(input int i);
    logic [7:0] p [9];
    p = '{mb, mc, r0c, r0d, r0e, r0f, r11, r12, r13};
    port_of = p[i];
  endfunction
  task chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task rc(input logic [7:0] a, input logic [7:0] e);
    ccrb_host_model_i.rd(a, v);
    chk(v, e);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] x);
    ccrb_host_model_i.wr(`CCRB_TARGET_ADDR, a, x, ok);
    chk({7'h00, ok}, 8'h01);
  endtask
  task all_dft;
    for (int i = 0; i < 9; i++)
      rc(ofs[i], exp_rd(ofs[i], dft[i]));
  endtask
  // Expiry pulse; samples status and idle once settled
  task tpulse;
    @(posedge clk);
    tmr <= 1'b1;
    @(posedge clk);
    tmr <= 1'b0;
    #1;
    got = {6'h00, stat, idle};
  endtask
  // One-cycle source event {removed, connected}
  task ev(input logic [1:0] e);
    @(posedge clk);
    {srem, scon} <= e;
    @(posedge clk);
    {srem, scon} <= 2'b00;
  endtask
  // Bounded wait for an absence test pulse
  task wait_p;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (abs_p !== 1'b1 && n < 200);
  endtask
  task done(input string s);
    $display("test %s finished", s);
  endtask
  task close_out;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Hang guard, well above the expected 30k cycles
  initial begin
    repeat (80000) @(posedge clk);
    errors++;
    $display("CHECK FAILED at %0t: watchdog", $time);
    close_out;
  end
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    all_dft;
    rc(8'h10, 8'h00);
    ccrb_host_model_i.wr(`CCRB_TARGET_ADDR ^ 7'h01, 8'h0c, 8'h00, ok);
    chk({7'h00, ok}, 8'h00);
    rc(8'h0c, 8'h3f);
    done("defaults");
    // Random traffic; soft reset bit kept clear here
    for (int k = 0; k < 27; k++) begin
      d = $random(seed);
      if (ofs[k % 9] == 8'h0f)
        d[7] = 1'b0;
      {fb, rdue, cbt, boost} <= $random(seed);
      wr(ofs[k % 9], d);
      rc(ofs[k % 9], exp_rd(ofs[k % 9], d));
      chk(exp_rd(ofs[k % 9], port_of(k % 9)), exp_rd(ofs[k % 9], d));
    end
    {fb, rdue, cbt, boost} <= 11'h000;
    for (int i = 0; i < 3; i++) begin
      wr(8'h12, fv[i]);
      chk({2'b00, fcode}, fv[i] > 8'h3c ? 8'h3c : fv[i]);
    end
    wr(8'h0f, 8'h80);
    all_dft;
    done("random");
    // Reserved mask bit cannot hide its flag
    fb <= 8'h02;
    wr(8'h09, 8'hff);
    chk({7'h00, irq_n}, 8'h00);
    fb <= 8'h40;
    wr(8'h09, 8'hff);
    chk({7'h00, irq_n}, 8'h01);
    fb <= 8'h00;
    fc <= 8'h01;
    wr(8'h0a, 8'h01);
    chk({7'h00, irq_n}, 8'h00);
    wr(8'h0e, 8'h9c);
    chk({7'h00, irq_n}, 8'h01);
    fc <= 8'h00;
    tpulse;
    chk(got, 8'h02);
    rc(8'h0a, 8'h01);
    wr(8'h0e, 8'h1c);
    tpulse;
    chk(got, 8'h03);
    rc(8'h09, 8'h00);
    rc(8'h0a, 8'h00);
    done("mask and expiry");
    blow <= 1'b1;
    wr(8'h0e, 8'h1e);
    rc(8'h0e, 8'h1c);
    blow <= 1'b0;
    boost <= 1'b1;
    wr(8'h0e, 8'h1e);
    chk({7'h00, hz}, 8'h00);
    boost <= 1'b0;
    repeat (3) @(posedge clk);
    chk({7'h00, hz}, 8'h01);
    blow <= 1'b1;
    repeat (3) @(posedge clk);
    blow <= 1'b0;
    rc(8'h0e, 8'h1c);
    done("high impedance");
    wr(8'h0f, 8'h44);
    ev(2'b10);
    rc(8'h0f, 8'h46);
    ev(2'b01);
    rc(8'h0f, 8'h40);
    wr(8'h0f, 8'h42);
    ev(2'b10);
    rc(8'h0f, 8'h40);
    done("ship mode");
    absent <= 1'b1;
    wait_p;
    wait_p;
    chk(8'(n), 8'(PER));
    chk({7'h00, bsw}, 8'h01);
    wr(8'h0e, 8'h0c);
    wait_p;
    chk(8'(n), 8'd200);
    chk({7'h00, bsw}, 8'h00);
    done("no battery");
    close_out;
  end
endmodule // tb_top
`default_nettype wire
